/* File: pkg/bdm_cfg.svh */
`ifndef BDM_CFG_SVH
`define BDM_CFG_SVH
// Register offsets
`define BDM_OFS_CTRL 8'h00
`define BDM_OFS_GIE 8'h04
`define BDM_OFS_IER 8'h08
`define BDM_OFS_ISR 8'h0c
`define BDM_OFS_WIDTH 8'h10
`define BDM_OFS_HEIGHT 8'h18
`define BDM_OFS_PHASE 8'h28
`define BDM_OFS_BUILD 8'h30
// Control fields
`define BDM_CTRL_START 0
`define BDM_CTRL_DONE 1
`define BDM_CTRL_IDLE 2
`define BDM_CTRL_READY 3
`define BDM_CTRL_AUTO 7
// Build defaults
`define BDM_SPC_DEFAULT 1
`define BDM_DW_DEFAULT 8
`define BDM_COLS_DEFAULT 3840
`define BDM_ROWS_DEFAULT 2160
`define BDM_ALGO_DEFAULT 0
`define BDM_ZIPPER_DEFAULT 1
`define BDM_LARGE_RAM_DEFAULT 0
// Reset values and responses
`define BDM_REG_RESET 32'h0000_0000
`define BDM_RESP_OKAY 2'h0
`define BDM_RESP_SLVERR 2'h2
`endif

/* File: pkg/bdm_pkg.sv */
package bdm_pkg;
  typedef enum logic {bdm_high_res, bdm_fringe} bdm_algo_type;
  typedef enum logic {bdm_idle, bdm_run} bdm_state_type;
  typedef enum logic [1:0] {bdm_red, bdm_green, bdm_blue} bdm_site_type;
endpackage

/* File: core/bdm_core.sv */
// What this block does
// RULE_01: Only the reset pin resets the core; no register does.
// RULE_02: Controller holds reset low at least sixteen core clocks; the test's first reset holds it low ten.
// RULE_03: Reset is sampled synchronously on the one core clock.
// RULE_04: Reset clears control port, both streams and all state; here the line buffer lbuf_reg keeps its contents through reset.
// RULE_05: Software programs width and height to match arriving frames.
// RULE_06: Settings other than size take effect from the next frame.
// RULE_07: System disables and re-enables cores from output toward input.
// RULE_08: Pixels per beat are a build choice of 1, 2, 4 or 8.
// RULE_09: Component width is a build choice of 8, 10, 12 or 16.
// RULE_10: Build column limit, default 3840, bounds run-time width.
// RULE_11: Build row limit, default 2160, bounds run-time height.
// RULE_12: Build selector: 0 high resolution, 1 fringe tolerant.
// RULE_13: Optional horizontal smoothing filter removes zipper artifacts.
// RULE_14: Build option places line buffers in large on-chip RAM; here large_line_ram only shows in the build word.
// RULE_15: Control port and both streams share the single clock.
// RULE_16: Reset is active low; core stays reset while low.
`timescale 1ns/1ns
`include "bdm_cfg.svh"
module bdm_core #(
  parameter int samples_per_beat = `BDM_SPC_DEFAULT,
  parameter int component_width = `BDM_DW_DEFAULT,
  parameter int column_limit = `BDM_COLS_DEFAULT,
  parameter int row_limit = `BDM_ROWS_DEFAULT,
  parameter bdm_pkg::bdm_algo_type interpolation_select =
    bdm_pkg::bdm_algo_type'(`BDM_ALGO_DEFAULT),
  parameter bit zipper_removal = `BDM_ZIPPER_DEFAULT,
  parameter bit large_line_ram = `BDM_LARGE_RAM_DEFAULT
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic s_axis_tvalid,
  output logic s_axis_tready,
  input wire logic [samples_per_beat*component_width-1:0] s_axis_tdata,
  input wire logic s_axis_tuser,
  input wire logic s_axis_tlast,
  output logic m_axis_tvalid,
  input wire logic m_axis_tready,
  output logic [3*samples_per_beat*component_width-1:0] m_axis_tdata,
  output logic m_axis_tuser,
  output logic m_axis_tlast
);
  // ----------------------------------------
  // Build-time shape
  // ----------------------------------------
  localparam int SPC = samples_per_beat; // RULE_08
  localparam int DW = component_width; // RULE_09
  localparam int LW = SPC * DW;
  localparam int PW = 3 * DW;
  localparam int SH = $clog2(SPC);
  localparam int DEPTH = column_limit / SPC; // RULE_10
  localparam int AW = $clog2(DEPTH);
  localparam int CW = 16;

  // Pick the smaller of two values, used by both frame dimensions
  function automatic logic [CW-1:0] clamp(input logic [CW-1:0] v,
                                          input logic [CW-1:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  // Rounded-down mean of two components
  function automatic logic [DW-1:0] avg(input logic [DW-1:0] a,
                                        input logic [DW-1:0] b);
    logic [DW:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[DW:1];
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Colour estimate of one site: {red, green, blue}
  function automatic logic [PW-1:0] interp(input logic [DW-1:0] s,
      input logic [DW-1:0] lf, input logic [DW-1:0] up,
      input bdm_pkg::bdm_site_type site);
    logic [DW-1:0] mid;
    // Fringe tolerant blends neighbours: softer, less colour fringing
    mid = (interpolation_select == bdm_pkg::bdm_fringe) ?
          avg(lf, up) : lf; // RULE_12
    unique case (site)
      bdm_pkg::bdm_red: return {s, mid, up};
      bdm_pkg::bdm_blue: return {up, mid, s};
      default: return {lf, s, up};
    endcase
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic aw_have_reg, w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] ctrl_reg, gie_reg, ier_reg, width_reg, height_reg;
  logic [31:0] phase_reg;
  logic done_reg;
  bdm_pkg::bdm_state_type state_reg;
  logic [CW-1:0] fbeats_reg, fheight_reg, col_reg, row_reg;
  logic [1:0] fphase_reg;
  logic [DW-1:0] prev_s_reg;
  logic [PW-1:0] prev_rgb_reg;
  logic [LW-1:0] lbuf_reg [DEPTH];
  logic in_ready_reg, out_valid_reg, out_user_reg, out_last_reg;
  logic [3*LW-1:0] out_data_reg;

  // ----------------------------------------
  // Register bus decode
  // ----------------------------------------
  wire aw_fire = s_axi_awvalid && awready_reg;
  wire w_fire = s_axi_wvalid && wready_reg;
  wire ar_fire = s_axi_arvalid && arready_reg;
  wire do_write = aw_have_reg && w_have_reg && !bvalid_reg;
  wire [7:0] ra = s_axi_araddr[7:0];
  wire wr_ctrl = do_write && aw_addr_reg == `BDM_OFS_CTRL;
  wire wr_gie = do_write && aw_addr_reg == `BDM_OFS_GIE;
  wire wr_ier = do_write && aw_addr_reg == `BDM_OFS_IER;
  wire wr_width = do_write && aw_addr_reg == `BDM_OFS_WIDTH;
  wire wr_height = do_write && aw_addr_reg == `BDM_OFS_HEIGHT;
  wire wr_phase = do_write && aw_addr_reg == `BDM_OFS_PHASE;
  wire wr_ro = aw_addr_reg == `BDM_OFS_ISR ||
               aw_addr_reg == `BDM_OFS_BUILD;
  wire wr_hit = wr_ctrl || wr_gie || wr_ier || wr_width || wr_height ||
                wr_phase || wr_ro;
  wire rd_ctrl = ar_fire && ra == `BDM_OFS_CTRL;
  wire [31:0] wmerged = merge(ctrl_reg, w_data_reg, w_strb_reg);
  // Old word of the addressed setting, so strobes keep other lanes
  wire [31:0] wr_old = (aw_addr_reg == `BDM_OFS_GIE) ? gie_reg :
    (aw_addr_reg == `BDM_OFS_IER) ? ier_reg :
    (aw_addr_reg == `BDM_OFS_WIDTH) ? width_reg :
    (aw_addr_reg == `BDM_OFS_HEIGHT) ? height_reg : phase_reg;
  wire [31:0] wr_new = merge(wr_old, w_data_reg, w_strb_reg);
  // Handshake ready terms; one write and one read outstanding at most
  wire aw_have_next = !do_write && (aw_have_reg || aw_fire);
  wire w_have_next = !do_write && (w_have_reg || w_fire);
  wire bvalid_next = do_write || (bvalid_reg && !s_axi_bready);
  wire rvalid_next = ar_fire || (rvalid_reg && !s_axi_rready);
  wire busy = state_reg == bdm_pkg::bdm_run;
  // Read-back of build choices, so software can see the instance shape
  wire [31:0] build_word = {1'b0, large_line_ram, zipper_removal, // RULE_14
    interpolation_select == bdm_pkg::bdm_fringe, 4'(SH), 8'(DW),
    16'(column_limit)}; // RULE_13
  wire [31:0] ctrl_view = {ctrl_reg[31:8], ctrl_reg[`BDM_CTRL_AUTO],
    3'h0, !busy, !busy, done_reg, ctrl_reg[`BDM_CTRL_START]};
  wire rd_hit = ra == `BDM_OFS_CTRL || ra == `BDM_OFS_GIE ||
    ra == `BDM_OFS_IER || ra == `BDM_OFS_ISR || ra == `BDM_OFS_WIDTH ||
    ra == `BDM_OFS_HEIGHT || ra == `BDM_OFS_PHASE || ra == `BDM_OFS_BUILD;
  wire [31:0] rd_word =
    (ra == `BDM_OFS_CTRL) ? ctrl_view :
    (ra == `BDM_OFS_GIE) ? gie_reg :
    (ra == `BDM_OFS_IER) ? ier_reg :
    (ra == `BDM_OFS_WIDTH) ? width_reg :
    (ra == `BDM_OFS_HEIGHT) ? height_reg :
    (ra == `BDM_OFS_PHASE) ? phase_reg :
    (ra == `BDM_OFS_BUILD) ? build_word : `BDM_REG_RESET;

  // ----------------------------------------
  // Frame sequencing
  // ----------------------------------------
  wire in_fire = s_axis_tvalid && in_ready_reg;
  // Beats outside a frame are dropped until a start-of-frame arrives
  wire proc = in_fire && (busy || s_axis_tuser);
  wire sof = proc && !busy;
  // Size and phase are captured at frame start only, never mid-frame
  wire [CW-1:0] beats_now = busy ? fbeats_reg :
    clamp(width_reg[CW-1:0], CW'(column_limit)) >> SH; // RULE_10
  wire [CW-1:0] rows_now = busy ? fheight_reg :
    clamp(height_reg[CW-1:0], CW'(row_limit)); // RULE_11
  wire [1:0] phase_now = busy ? fphase_reg : phase_reg[1:0]; // RULE_06
  wire eol = col_reg == beats_now - CW'(1);
  wire eof = proc && eol && row_reg == rows_now - CW'(1);
  wire start_set = wr_ctrl && wmerged[`BDM_CTRL_START];
  wire start_clr = sof && !ctrl_reg[`BDM_CTRL_AUTO];
  wire out_valid_next = proc || (out_valid_reg && !m_axis_tready);
  wire run_ok_next = busy ? !eof : (ctrl_reg[`BDM_CTRL_START] ||
    start_set);
  // Registered ready costs throughput; keeps every output on a flop
  wire in_ready_next = !out_valid_next && run_ok_next && !in_fire;
  wire [AW-1:0] lb_idx = col_reg[AW-1:0];

  // ----------------------------------------
  // Interpolation datapath
  // ----------------------------------------
  logic [3*LW-1:0] rgb_next;
  logic [DW-1:0] last_s_next;
  logic [PW-1:0] last_rgb_next;
  always_comb begin
    logic [DW-1:0] s, lf, up;
    logic [PW-1:0] raw, zl, sm;
    logic codd, rodd;
    bdm_pkg::bdm_site_type site;
    s = '0;
    up = '0;
    raw = '0;
    sm = '0;
    codd = 1'b0;
    rodd = 1'b0;
    site = bdm_pkg::bdm_green;
    rgb_next = '0;
    lf = (col_reg == '0) ? s_axis_tdata[DW-1:0] : prev_s_reg;
    zl = prev_rgb_reg;
    last_s_next = prev_s_reg;
    last_rgb_next = prev_rgb_reg;
    for (int k = 0; k < SPC; k++) begin
      s = s_axis_tdata[k*DW +: DW];
      up = (row_reg == '0) ? s : lbuf_reg[lb_idx][k*DW +: DW];
      codd = (SPC == 1) ? col_reg[0] : 1'(k % 2);
      rodd = row_reg[0];
      if (rodd == phase_now[1] && codd == phase_now[0]) begin
        site = bdm_pkg::bdm_red;
      end else if (rodd != phase_now[1] && codd != phase_now[0]) begin
        site = bdm_pkg::bdm_blue;
      end else begin
        site = bdm_pkg::bdm_green;
      end
      raw = interp(s, lf, up, site);
      if (col_reg == '0 && k == 0) begin
        zl = raw;
      end
      // Horizontal smoothing against the left neighbour
      sm = {avg(raw[PW-1 -: DW], zl[PW-1 -: DW]),
            avg(raw[DW +: DW], zl[DW +: DW]),
            avg(raw[DW-1:0], zl[DW-1:0])};
      rgb_next[k*PW +: PW] = zipper_removal ? sm : raw; // RULE_13
      lf = s;
      zl = raw;
    end
    last_s_next = lf;
    last_rgb_next = zl;
  end

  // ----------------------------------------
  // Bus handshake flops
  // ----------------------------------------
  // Synchronous active-low reset on the one core clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin // RULE_03 RULE_16 RULE_15
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awready_reg <= !aw_have_next && !bvalid_next;
      wready_reg <= !w_have_next && !bvalid_next;
      bvalid_reg <= bvalid_next;
      arready_reg <= !rvalid_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Bus payload capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin // RULE_04
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bresp_reg <= `BDM_RESP_OKAY;
      rresp_reg <= `BDM_RESP_OKAY;
      rdata_reg <= '0;
    end else begin
      if (aw_fire) aw_addr_reg <= s_axi_awaddr[7:0];
      if (w_fire) w_data_reg <= s_axi_wdata;
      if (w_fire) w_strb_reg <= s_axi_wstrb;
      if (do_write) bresp_reg <= wr_hit ? `BDM_RESP_OKAY : `BDM_RESP_SLVERR;
      if (ar_fire) rresp_reg <= rd_hit ? `BDM_RESP_OKAY : `BDM_RESP_SLVERR;
      if (ar_fire) rdata_reg <= rd_word;
    end
  end

  // ----------------------------------------
  // Software-visible settings
  // ----------------------------------------
  // No bit here resets the core; only the pin does
  always_ff @(posedge aclk) begin
    if (!aresetn) begin // RULE_01 RULE_04
      ctrl_reg <= `BDM_REG_RESET;
      gie_reg <= `BDM_REG_RESET;
      ier_reg <= `BDM_REG_RESET;
      width_reg <= `BDM_REG_RESET;
      height_reg <= `BDM_REG_RESET;
      phase_reg <= `BDM_REG_RESET;
      done_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg[`BDM_CTRL_AUTO] <= wmerged[`BDM_CTRL_AUTO];
      end
      // A write of start beats a same-cycle frame-start clear
      if (start_set) ctrl_reg[`BDM_CTRL_START] <= 1'b1;
      else if (start_clr) ctrl_reg[`BDM_CTRL_START] <= 1'b0;
      if (wr_gie) gie_reg <= {31'h0, wr_new[0]};
      if (wr_ier) ier_reg <= {30'h0, wr_new[1:0]};
      if (wr_width) width_reg <= {16'h0, wr_new[15:0]};
      if (wr_height) height_reg <= {16'h0, wr_new[15:0]};
      if (wr_phase) phase_reg <= {30'h0, wr_new[1:0]};
      // Frame end sets done; read of control clears, set wins
      done_reg <= eof || (done_reg && !rd_ctrl);
    end
  end

  // ----------------------------------------
  // Frame counters and line buffer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin // RULE_04
      state_reg <= bdm_pkg::bdm_idle;
      fbeats_reg <= '0;
      fheight_reg <= '0;
      fphase_reg <= '0;
      col_reg <= '0;
      row_reg <= '0;
      prev_s_reg <= '0;
      prev_rgb_reg <= '0;
    end else begin
      if (sof) begin // RULE_06
        state_reg <= bdm_pkg::bdm_run;
        fbeats_reg <= beats_now;
        fheight_reg <= rows_now;
        fphase_reg <= phase_now;
      end
      if (eof) state_reg <= bdm_pkg::bdm_idle;
      if (proc) begin
        col_reg <= eol ? '0 : col_reg + CW'(1);
        row_reg <= eof ? '0 : (eol ? row_reg + CW'(1) : row_reg);
        prev_s_reg <= last_s_next;
        prev_rgb_reg <= last_rgb_next;
      end
    end
  end

  // Row store; the same register array whatever large_line_ram is set to
  always_ff @(posedge aclk) begin
    if (proc && col_reg < CW'(DEPTH)) begin // RULE_14
      lbuf_reg[lb_idx] <= s_axis_tdata;
    end
  end

  // ----------------------------------------
  // Stream flops
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin // RULE_04
      in_ready_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_user_reg <= 1'b0;
      out_last_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      in_ready_reg <= in_ready_next;
      out_valid_reg <= out_valid_next;
      if (proc) begin
        out_data_reg <= rgb_next;
        out_user_reg <= sof;
        out_last_reg <= eol; // RULE_05
      end
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axis_tready = in_ready_reg;
  assign m_axis_tvalid = out_valid_reg;
  assign m_axis_tdata = out_data_reg;
  assign m_axis_tuser = out_user_reg;
  assign m_axis_tlast = out_last_reg;
endmodule // bdm_core

/* File: dv/bdm_core_chk.sv */
`timescale 1ns/1ns
// --------------------------
// Port checks for the core
// --------------------------
module bdm_core_chk #(
  parameter int samples_per_beat = 1,
  parameter int component_width = 8
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axis_tvalid,
  input wire logic s_axis_tready,
  input wire logic s_axis_tuser,
  input wire logic m_axis_tvalid,
  input wire logic m_axis_tready,
  input wire logic [3*samples_per_beat*component_width-1:0] m_axis_tdata,
  input wire logic m_axis_tuser,
  input wire logic m_axis_tlast
);
  default clocking chk_cb @(posedge aclk);
  endclocking
  // Write steps: both channels taken, one held cycle, then the answer
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  sequence beat_in;
    s_axis_tvalid && s_axis_tready;
  endsequence
  // Reset checks carry no disable: they watch the reset itself
  AST_RST_STREAM: assert property (
    !aresetn |=> !s_axis_tready && !m_axis_tvalid)
    else $error("stream outputs active after a reset edge");
  AST_RST_BUS: assert property (
    !aresetn |=> !s_axi_awready && !s_axi_wready && !s_axi_arready
      && !s_axi_bvalid && !s_axi_rvalid)
    else $error("control port active after a reset edge");
  AST_RST_SYNC: assert property (
    $rose(aresetn) |-> ##1 !s_axi_bvalid && !s_axi_rvalid && !m_axis_tvalid)
    else $error("answer raised at the release edge");
  AST_WR_ANSWER: assert property (
    disable iff (!aresetn) wr_take |=> b_answer)
    else $error("write answer not two cycles after handshake");
  AST_B_DROP: assert property (
    disable iff (!aresetn) s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stayed after handshake");
  AST_R_ANSWER: assert property (
    disable iff (!aresetn) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  AST_R_DROP: assert property (
    disable iff (!aresetn) s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer stayed after handshake");
  AST_M_HOLD: assert property (
    disable iff (!aresetn) m_axis_tvalid && !m_axis_tready |=>
      m_axis_tvalid && $stable(m_axis_tdata) && $stable(m_axis_tuser)
      && $stable(m_axis_tlast))
    else $error("output beat changed while stalled");
  AST_S_GAP: assert property (
    disable iff (!aresetn) beat_in |=> !s_axis_tready)
    else $error("input ready stayed up after a beat");
  AST_SOF: assert property (
    disable iff (!aresetn) beat_in ##0 s_axis_tuser |=>
      m_axis_tvalid && m_axis_tuser)
    else $error("frame start not marked on the next output");
endmodule // bdm_core_chk

bind bdm_core bdm_core_chk #(
  .samples_per_beat(samples_per_beat),
  .component_width(component_width)
) bdm_core_chk_inst (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axis_tvalid(s_axis_tvalid), .s_axis_tready(s_axis_tready),
  .s_axis_tuser(s_axis_tuser), .m_axis_tvalid(m_axis_tvalid),
  .m_axis_tready(m_axis_tready), .m_axis_tdata(m_axis_tdata),
  .m_axis_tuser(m_axis_tuser), .m_axis_tlast(m_axis_tlast)
);

/* File: dv/bdm_sink_model.sv */
`timescale 1ns/1ns
// Downstream sink; may stall at any cycle, as a real one does
module bdm_sink_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stall,
  output logic m_axis_tready
);
  // Sink comes up ready before the source is started
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_axis_tready <= 1'b0;
    end else begin
      m_axis_tready <= !stall;
    end
  end
endmodule // bdm_sink_model

/* File: dv/bayer_demosaic_reset_config_test.sv */
`timescale 1ns/1ns
`include "bdm_cfg.svh"
module bayer_demosaic_reset_config_test;
  // ------------------
  // Bench state
  // ------------------
  localparam int col_lim = 8;
  localparam int row_lim = 4;
  localparam int tmo_limit = 20000;
  localparam logic [31:0] build_word = 32'h2008_0008;
  logic aclk = 1'b0, aresetn = 1'b0, stall = 1'b0, stall_on = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, tvalid = 1'b0, tuser = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [31:0] rdata, seed = 32'h6a13;
  logic [7:0] tdata = 8'h0, sof_s = 8'h0;
  logic [23:0] mdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, tready;
  logic mvalid, mready, muser, mlast;
  logic [31:0] model_reg [0:63];
  logic [1:0] exp_q [$];
  logic [7:0] all_offs [8] = '{`BDM_OFS_CTRL, `BDM_OFS_GIE, `BDM_OFS_IER,
    `BDM_OFS_ISR, `BDM_OFS_WIDTH, `BDM_OFS_HEIGHT, `BDM_OFS_PHASE,
    `BDM_OFS_BUILD};
  int err_count = 0, checks = 0, cycles = 0;

  always #25 aclk = ~aclk;

  bdm_core #(.column_limit(col_lim), .row_limit(row_lim)) bdm_core_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axis_tvalid(tvalid),
    .s_axis_tready(tready), .s_axis_tdata(tdata), .s_axis_tuser(tuser),
    .s_axis_tlast(1'b0), .m_axis_tvalid(mvalid), .m_axis_tready(mready),
    .m_axis_tdata(mdata), .m_axis_tuser(muser), .m_axis_tlast(mlast));

  bdm_sink_model bdm_sink_model_inst (.aclk(aclk), .aresetn(aresetn),
    .stall(stall), .m_axis_tready(mready));

  // ------------------
  // Helpers and model
  // ------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Only stored fields survive a write; the rest reads back zero
  function automatic logic [31:0] wmask(input logic [7:0] a);
    case (a)
      `BDM_OFS_GIE: return 32'h1;
      `BDM_OFS_IER, `BDM_OFS_PHASE: return 32'h3;
      `BDM_OFS_WIDTH, `BDM_OFS_HEIGHT: return 32'hffff;
      default: return 32'h0;
    endcase
  endfunction

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp_word({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic model_init();
    foreach (model_reg[i]) model_reg[i] = 32'h0;
    model_reg[0] = 32'hc;
    model_reg[`BDM_OFS_BUILD >> 2] = build_word;
  endtask

  task automatic do_reset(input int n);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (n) @(posedge aclk);
    cmp_bit(tready, 1'b0, "input ready in reset");
    cmp_bit(mvalid, 1'b0, "output valid in reset");
    exp_q.delete();
    model_init();
    aresetn <= 1'b1;
  endtask

  // Write master: offer both channels, drop each when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp_word({30'h0, bresp}, {30'h0, er}, "write response");
    model_reg[a[7:2]] = (model_reg[a[7:2]] & ~wmask(a)) | (d & wmask(a));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    cmp_word({30'h0, rresp}, {30'h0, er}, "read response");
    cmp_word(rdata, model_reg[a[7:2]], "read data");
    if (a == `BDM_OFS_CTRL) model_reg[0][1] = 1'b0;
  endtask

  // Program size, start, then feed up to stop beats of the frame
  task automatic run_frame(input int w, input int h, input int stop);
    int bpl, n;
    bpl = (w < col_lim) ? w : col_lim;
    n = bpl * ((h < row_lim) ? h : row_lim);
    n = (stop < n) ? stop : n;
    axi_wr(`BDM_OFS_WIDTH, 32'(w), `BDM_RESP_OKAY);
    axi_wr(`BDM_OFS_HEIGHT, 32'(h), `BDM_RESP_OKAY);
    axi_wr(`BDM_OFS_CTRL, 32'h1, `BDM_RESP_OKAY);
    for (int i = 0; i < n; i++) exp_q.push_back({i == 0, i % bpl == bpl - 1});
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      tvalid <= 1'b1;
      tuser <= (i == 0);
      tdata <= seed[7:0];
      if (i == 0) sof_s = seed[7:0];
      do @(posedge aclk); while (tready !== 1'b1);
      tvalid <= 1'b0;
      tuser <= 1'b0;
      tdata <= ~seed[7:0];
    end
  endtask

  task automatic end_frame(input string name);
    while (exp_q.size() != 0) @(posedge aclk);
    model_reg[0] = 32'he;
    axi_rd(`BDM_OFS_CTRL, `BDM_RESP_OKAY);
    axi_rd(`BDM_OFS_CTRL, `BDM_RESP_OKAY);
    $display("test done: %s", name);
  endtask

  // Output beats checked against the frame model; random stall, watchdog
  always @(posedge aclk) begin
    if (aresetn === 1'b1 && mvalid === 1'b1 && mready === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp_bit(1'b1, 1'b0, "unexpected output beat");
      end else begin
        cmp_word({30'h0, muser, mlast}, {30'h0, exp_q.pop_front()},
          "beat flags");
        // Corner pixel has no neighbours: every component is the sample
        if (muser === 1'b1) begin
          cmp_word({8'h0, mdata}, {8'h0, {3{sof_s}}},
            "corner pixel");
        end
      end
    end
    seed <= xs(seed);
    stall <= stall_on & seed[0];
    cycles++;
    if (cycles == tmo_limit) begin
      err_count++;
      final_report();
    end
  end

  // ------------------
  // Test sequence
  // ------------------
  initial begin
    model_init();
    do_reset(10);
    foreach (all_offs[i]) axi_rd(all_offs[i], 2'h0);
    for (int i = 1; i < 7; i++) begin
      axi_wr(all_offs[i], seed, `BDM_RESP_OKAY);
      axi_rd(all_offs[i], `BDM_RESP_OKAY);
    end
    axi_wr(`BDM_OFS_BUILD, 32'hffffffff, `BDM_RESP_OKAY);
    axi_wr(8'h40, 32'hffffffff, `BDM_RESP_SLVERR);
    axi_rd(8'h40, `BDM_RESP_SLVERR);
    foreach (all_offs[i]) axi_rd(all_offs[i], 2'h0);
    $display("test done: registers");
    stall_on <= 1'b1;
    run_frame(4, 2, 99);
    end_frame("small frame");
    axi_wr(`BDM_OFS_PHASE, 32'h3, `BDM_RESP_OKAY);
    run_frame(100, 9, 999);
    end_frame("clipped frame");
    run_frame(4, 2, 3);
    do_reset(16);
    foreach (all_offs[i]) axi_rd(all_offs[i], 2'h0);
    run_frame(4, 2, 99);
    end_frame("reset mid frame");
    final_report();
  end
endmodule // bayer_demosaic_reset_config_test
